// ==== design/irq_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the vectored priority interrupt controller
// Assumes: 16-bit registers reached over a 32-bit Avalon-MM slave, one word each
// Notes:   Only the first request-flag bank lives here; other banks are handled elsewhere
`default_nettype none
package irq_ctrl_pkg;
  localparam int unsigned REG_W        = 16;
  localparam int unsigned NSRC         = 16;
  localparam int unsigned PRIO_W       = 3;
  localparam int unsigned LVL_W        = 4;
  localparam int unsigned VEC_W        = 24;
  localparam int unsigned ADDR_W       = 6;

  // Byte offsets of the register words
  localparam logic [5:0] OFF_STATUS    = 6'h00;
  localparam logic [5:0] OFF_CORE      = 6'h04;
  localparam logic [5:0] OFF_CTL_ONE   = 6'h08;
  localparam logic [5:0] OFF_CTL_TWO   = 6'h0C;
  localparam logic [5:0] OFF_FLAGS     = 6'h10;
  localparam logic [5:0] OFF_ENABLE    = 6'h14;
  localparam logic [5:0] OFF_PRIO0     = 6'h18;
  localparam logic [5:0] OFF_PRIO3     = 6'h24;
  localparam logic [5:0] OFF_VECTOR    = 6'h28;

  // Field positions
  localparam int unsigned CPL_LSB      = 5;
  localparam int unsigned CPL_TOP_BIT  = 3;
  localparam int unsigned NEST_BIT     = 15;
  localparam int unsigned ARITH_BIT    = 4;
  localparam int unsigned ADDR_BIT     = 3;
  localparam int unsigned STACK_BIT    = 2;
  localparam int unsigned OSC_BIT      = 1;
  localparam int unsigned ALT_BIT      = 15;
  localparam int unsigned TDIS_BIT     = 14;

  // Reset values
  localparam logic [REG_W-1:0] RST_ZERO = 16'h0000;
  localparam logic [LVL_W-1:0] RST_LVL  = 4'h0;

  // Implemented bits of the first flag bank, trap flags, polarity and priority fields
  localparam logic [REG_W-1:0] FLAG_MASK = 16'h3FEF;
  localparam logic [REG_W-1:0] TRAP_MASK = 16'h001E;
  localparam logic [REG_W-1:0] POL_MASK  = 16'h0007;
  localparam logic [REG_W-1:0] PRIO_MASK = 16'h7777;

  // Vector table bases and timer, serial and USB vector numbers
  localparam logic [VEC_W-1:0] DEF_BASE  = 24'h000014;
  localparam logic [VEC_W-1:0] ALT_OFS   = 24'h000100;
  localparam logic [6:0] VEC_TMR1 = 7'h03;
  localparam logic [6:0] VEC_TMR2 = 7'h07;
  localparam logic [6:0] VEC_TMR3 = 7'h08;
  localparam logic [6:0] VEC_TMR4 = 7'h1B;
  localparam logic [6:0] VEC_TMR5 = 7'h1C;
  localparam logic [6:0] VEC_UART1_ERR = 7'h41;
  localparam logic [6:0] VEC_UART1_RX  = 7'h0B;
  localparam logic [6:0] VEC_UART1_TX  = 7'h0C;
  localparam logic [6:0] VEC_USB       = 7'h56;

  typedef struct packed {
    logic arith;
    logic addr;
    logic stack;
    logic osc;
  } trap_ev_t;

  typedef struct packed {
    logic             valid;
    logic [6:0]       vec_num;
    logic [VEC_W-1:0] vec_addr;
    logic [PRIO_W-1:0] prio;
  } irq_req_t;
endpackage : irq_ctrl_pkg
`default_nettype wire

// ==== design/prio_pick.sv ====
// Purpose: Picks the winning pending source of one flag bank
// Assumes: Source index equals vector number within the bank
// Notes:   Lowest index wins among equal priorities; result is registered
`default_nettype none
module prio_pick #(
  parameter int unsigned N  = 16,
  parameter int unsigned PW = 3
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [N-1:0]  pend,
  input  wire logic [N*PW-1:0] prio,
  output logic               win_valid,
  output logic [6:0]         win_idx,
  output logic [PW-1:0]      win_prio
);
  if (N < 1 || N > 128) begin : g_bad_n
    $error("prio_pick: N out of range");
  end

  logic          best_v;
  logic [6:0]    best_i;
  logic [PW-1:0] best_p;

  // Strictly greater keeps the lower index on ties
  always_comb begin
    best_v = 1'b0;
    best_i = 7'h00;
    best_p = '0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && (!best_v || prio[i*PW +: PW] > best_p)) begin
        best_v = 1'b1;
        best_i = 7'(i);
        best_p = prio[i*PW +: PW];
      end
    end
  end

  // Registered result
  always_ff @(posedge clk) begin
    if (srst) begin
      win_valid <= 1'b0;
      win_idx   <= 7'h00;
      win_prio  <= '0;
    end else begin
      win_valid <= best_v;
      win_idx   <= best_i;
      win_prio  <= best_p;
    end
  end
endmodule // prio_pick
`default_nettype wire

// ==== design/irq_ctrl.sv ====
// Purpose: Vectored priority interrupt controller, first source bank and global control
// Assumes: Avalon-MM slave, 32-bit data, low 16 bits used; events are synchronised pulses
// Notes:   External pins pass a two-stage synchroniser before edge detection
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
// Functional notes
// - Each source has a flag set by hardware, cleared only by software
// - Each source has its own software enable bit
// - Each source has a 3-bit priority, one of eight levels
// - Flag, enable and priority fields packed by vector number from bit 0
// - CPU level low bits at status bits 7:5, writable by software
// - Core control bit 3 is the level top bit; software cannot set it
// - Low bits give levels 0-7, or 8-15 with top bit; 7 blocks users
// - Nesting disable makes the CPU level low bits read-only
// - Control one bit 15 disables interrupt nesting
// - Control one holds sticky trap flags in bits 4..1
// - Control two bits 2..0 select external edge, 1 means falling
// - Timers map to vectors 3,7,8,27,28; alternate address is default plus 100h
// - USB uses vector 86 at C0h, alternate 1C0h, bank 5 bit 6
// - Serial port one uses vectors 65, 11 and 12
// - Unimplemented bits read zero and ignore writes
// - Alternate table select makes all vectors come from the alternate table
// - Equal priorities resolve to the lower vector number
module irq_ctrl
(
  input  wire logic                          SYS_CLK,
  input  wire logic                          SRST,
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                          AVS_READ,
  input  wire logic                          AVS_WRITE,
  input  wire logic [31:0]                   AVS_WRITEDATA,
  input  wire logic [3:0]                    AVS_BYTEENABLE,
  output logic [31:0]                        AVS_READDATA,
  output logic                               AVS_WAITREQUEST,
  input  wire logic [irq_ctrl_pkg::NSRC-1:0] SRC_EVENT,
  input  wire logic [2:0]                    EXT_IRQ_PIN,
  input  wire irq_ctrl_pkg::trap_ev_t        TRAP_EVENT,
  input  wire logic                          TEMP_DISABLE,
  input  wire logic                          CPU_LEVEL_LOAD,
  input  wire logic [irq_ctrl_pkg::LVL_W-1:0] CPU_LEVEL_IN,
  output irq_ctrl_pkg::irq_req_t             IRQ_REQ,
  output logic [irq_ctrl_pkg::LVL_W-1:0]     CPU_LEVEL,
  output logic                               NEST_DISABLE,
  output logic                               ALT_TABLE
);
  import irq_ctrl_pkg::*;

  // Register map, one 16-bit register per 32-bit word, upper half reads zero
  //   0x00  CPU status: level low bits at 7:5, locked while nesting is disabled
  //   0x04  Core control: level top bit at 3, clear-only from software
  //   0x08  Control one: nesting disable at 15, sticky trap flags at 4..1
  //   0x0C  Control two: table select 15, temporary disable 14, polarity 2..0
  //   0x10  Request flags of vectors 0..15
  //   0x14  Source enables of vectors 0..15
  //   0x18  Priorities of vectors 0..3, one nibble each, nibble top bit unused
  //   0x1C  Priorities of vectors 4..7
  //   0x20  Priorities of vectors 8..11
  //   0x24  Priorities of vectors 12..15
  //   0x28  Vector address of the current winner, read-only
  //   Anything else reads zero and ignores writes
  //   Byte enable bit 0 gates bits 7:0, bit 1 gates bits 15:8
  // Request path latency: a flag set at edge N reaches the winner register
  // at N+1 and the request output at N+2; a level change reaches the request
  // output at the very next edge, with no extra edge in between
  // Sources 0, 13 and 20-equivalent: bank zero holds ext irq zero at bit 0 only
  localparam int unsigned EXT0_SRC = 0;

  logic [REG_W-1:0] flags_q;
  logic [REG_W-1:0] enable_q;
  logic [REG_W-1:0] prio_q [4];
  logic [2:0]       cpl_low_q;
  logic             cpl_top_q;
  logic             nest_dis_q;
  logic [3:0]       trap_q;
  logic             alt_sel_q;
  logic [2:0]       polarity_q;
  logic             tdis_q;
  logic [2:0]       pin_s1_q;
  logic [2:0]       pin_s2_q;
  logic [2:0]       pin_prev_q;
  logic             ack_q;
  logic [31:0]      rdata_q;

  logic             acc;
  logic             wr_fire;
  logic             rd_fire;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] wmask;
  logic [2:0]       rise;
  logic [2:0]       fall;
  logic [2:0]       ext_edge;
  logic [NSRC-1:0]  set_vec;
  logic [NSRC*PRIO_W-1:0] prio_flat;
  logic             win_valid;
  logic [6:0]       win_idx;
  logic [PRIO_W-1:0] win_prio;
  logic [LVL_W-1:0] level;

  // Bus timing, seen from the master:
  //   cycle 0  request raised, waitrequest high, a read latches its data
  //   cycle 1  waitrequest low, a write lands at the closing edge
  //   The next request may follow directly; each access costs two cycles
  // Trade-off: a fixed wait state keeps read data registered, at one
  // extra cycle per access, which a core polling flags barely notices
  // One wait state per access; answer at the second edge of the request
  assign acc             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = acc & ~ack_q;
  assign wr_fire         = AVS_WRITE & ack_q;
  assign rd_fire         = AVS_READ & ~ack_q;
  assign wdata           = AVS_WRITEDATA[15:0];
  assign wmask           = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end

  // Two-stage synchroniser for the external pins, then edge detect on stage two
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pin_s1_q   <= 3'h0;
      pin_s2_q   <= 3'h0;
      pin_prev_q <= 3'h0;
    end else begin
      pin_s1_q   <= EXT_IRQ_PIN;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Edge detect on stage two only; stage one may still be settling
  assign rise     = pin_s2_q & ~pin_prev_q;
  assign fall     = ~pin_s2_q & pin_prev_q;
  assign ext_edge = (polarity_q & fall) | (~polarity_q & rise);

  // Only external irq zero lands in this bank; the others belong to later banks
  // Limitation: pins one and two only pass the edge logic here, their
  // flags are raised by the banks that own their vectors
  always_comb begin
    set_vec = SRC_EVENT & FLAG_MASK;
    set_vec[EXT0_SRC] = SRC_EVENT[EXT0_SRC] | ext_edge[0];
  end

  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      flags_q <= RST_ZERO;
    end else if (wr_fire && AVS_ADDRESS == OFF_FLAGS) begin
      flags_q <= (((flags_q & ~wmask) | (wdata & wmask)) | set_vec) & FLAG_MASK;
    end else begin
      flags_q <= (flags_q | set_vec) & FLAG_MASK;
    end
  end

  // Per-source enables
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      enable_q <= RST_ZERO;
    end else if (wr_fire && AVS_ADDRESS == OFF_ENABLE) begin
      enable_q <= ((enable_q & ~wmask) | (wdata & wmask)) & FLAG_MASK;
    end
  end

  // Priority registers, four 3-bit fields each
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 4; i++) begin
        prio_q[i] <= RST_ZERO;
      end
    end else if (wr_fire && AVS_ADDRESS >= OFF_PRIO0 && AVS_ADDRESS <= OFF_PRIO3) begin
      prio_q[2'(AVS_ADDRESS[5:2] - OFF_PRIO0[5:2])] <=
        ((prio_q[2'(AVS_ADDRESS[5:2] - OFF_PRIO0[5:2])] & ~wmask) | (wdata & wmask))
        & PRIO_MASK;
    end
  end

  // CPU level: software writes the low bits unless nesting is disabled
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cpl_low_q <= RST_LVL[2:0];
      cpl_top_q <= RST_LVL[3];
    end else if (CPU_LEVEL_LOAD) begin
      cpl_low_q <= CPU_LEVEL_IN[2:0];
      cpl_top_q <= CPU_LEVEL_IN[3];
    end else begin
      if (wr_fire && AVS_ADDRESS == OFF_STATUS && AVS_BYTEENABLE[0] && !nest_dis_q) begin
        cpl_low_q <= wdata[CPL_LSB +: 3];
      end
      // Top bit is clearable only, so traps stay unmaskable
      if (wr_fire && AVS_ADDRESS == OFF_CORE && AVS_BYTEENABLE[0] && !wdata[CPL_TOP_BIT]) begin
        cpl_top_q <= 1'b0;
      end
    end
  end

  // Control one: nesting disable and sticky traps
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      nest_dis_q <= 1'b0;
      trap_q     <= 4'h0;
    end else begin
      if (wr_fire && AVS_ADDRESS == OFF_CTL_ONE && AVS_BYTEENABLE[1]) begin
        nest_dis_q <= wdata[NEST_BIT];
      end
      if (wr_fire && AVS_ADDRESS == OFF_CTL_ONE && AVS_BYTEENABLE[0]) begin
        trap_q <= wdata[ARITH_BIT:OSC_BIT] | TRAP_EVENT;
      end else begin
        trap_q <= trap_q | TRAP_EVENT;
      end
    end
  end

  // Control two: table select, edge polarity and temporary disable status
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      alt_sel_q  <= 1'b0;
      polarity_q <= 3'h0;
      tdis_q     <= 1'b0;
    end else begin
      tdis_q <= TEMP_DISABLE;
      if (wr_fire && AVS_ADDRESS == OFF_CTL_TWO && AVS_BYTEENABLE[1]) begin
        alt_sel_q <= wdata[ALT_BIT];
      end
      if (wr_fire && AVS_ADDRESS == OFF_CTL_TWO && AVS_BYTEENABLE[0]) begin
        polarity_q <= wdata[2:0];
      end
    end
  end

  // Flatten priorities in vector order
  always_comb begin
    prio_flat = '0;
    for (int i = 0; i < NSRC; i++) begin
      prio_flat[i*PRIO_W +: PRIO_W] = prio_q[i/4][(i%4)*4 +: PRIO_W];
    end
  end

  prio_pick #(
    .N  (NSRC),
    .PW (PRIO_W)
  ) u_pick (
    .clk       (SYS_CLK),
    .srst      (SRST),
    .pend      (flags_q & enable_q),
    .prio      (prio_flat),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_prio  (win_prio)
  );

  // Four-bit CPU level; the top bit is set only by the core
  assign level = {cpl_top_q, cpl_low_q};

  // Request only when the winner beats the full four-bit level
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      IRQ_REQ <= '0;
    end else begin
      IRQ_REQ.valid    <= win_valid && ({1'b0, win_prio} > level);
      IRQ_REQ.vec_num  <= win_idx;
      IRQ_REQ.prio     <= win_prio;
      // No winner shows a zero address, so an idle vector word reads zero
      if (win_valid) begin
        IRQ_REQ.vec_addr <= DEF_BASE + VEC_W'({win_idx, 1'b0})
                            + (alt_sel_q ? ALT_OFS : '0);
      end else begin
        IRQ_REQ.vec_addr <= '0;
      end
    end
  end

  // Level and control outputs straight from their registers
  assign CPU_LEVEL    = level;
  assign NEST_DISABLE = nest_dis_q;
  assign ALT_TABLE    = alt_sel_q;

  // Read data registered on the first cycle, held for the answering edge
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      case (AVS_ADDRESS)
        OFF_STATUS:  rdata_q <= 32'({cpl_low_q, 5'h00});
        OFF_CORE:    rdata_q <= 32'({cpl_top_q, 3'h0});
        OFF_CTL_ONE: rdata_q <= 32'({nest_dis_q, 10'h000, trap_q, 1'b0});
        OFF_CTL_TWO: rdata_q <= 32'({alt_sel_q, tdis_q, 11'h000, polarity_q});
        OFF_FLAGS:   rdata_q <= 32'(flags_q);
        OFF_ENABLE:  rdata_q <= 32'(enable_q);
        OFF_PRIO0:   rdata_q <= 32'(prio_q[0]);
        6'h1C:       rdata_q <= 32'(prio_q[1]);
        6'h20:       rdata_q <= 32'(prio_q[2]);
        OFF_PRIO3:   rdata_q <= 32'(prio_q[3]);
        OFF_VECTOR:  rdata_q <= 32'(IRQ_REQ.vec_addr);
        default:     rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Read data always from the register, never from the decode
  assign AVS_READDATA = rdata_q;
endmodule // irq_ctrl
`default_nettype wire

// ==== dv/irq_ctrl_properties.sv ====
// Purpose: Port-level properties of the interrupt controller
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every irq_ctrl instance
`default_nettype none
module irq_ctrl_properties (
  input wire logic                    SYS_CLK,
  input wire logic                    SRST,
  input wire logic [5:0]              AVS_ADDRESS,
  input wire logic                    AVS_WRITE,
  input wire logic [31:0]             AVS_WRITEDATA,
  input wire logic [3:0]              AVS_BYTEENABLE,
  input wire logic [31:0]             AVS_READDATA,
  input wire logic                    AVS_WAITREQUEST,
  input wire logic                    CPU_LEVEL_LOAD,
  input wire logic [3:0]              CPU_LEVEL_IN,
  input wire irq_ctrl_pkg::irq_req_t  IRQ_REQ,
  input wire logic [3:0]              CPU_LEVEL,
  input wire logic                    NEST_DISABLE,
  input wire logic                    ALT_TABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // Status write that completes while the core is not loading a level
  sequence s_stat_wr;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_STATUS && AVS_BYTEENABLE[0]
      && !CPU_LEVEL_LOAD;
  endsequence
  // Top bit of a control word lands on its control output
  property p_wr_bit(logic [5:0] a, logic o);
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == a && AVS_BYTEENABLE[1]
      |=> o == $past(AVS_WRITEDATA[15]);
  endproperty
  AST_RD_HIGH_ZERO: assert property (AVS_READDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_LVL_WRITE: assert property (s_stat_wr ##0 !NEST_DISABLE
    |=> CPU_LEVEL[2:0] == $past(AVS_WRITEDATA[7:5])) else $error("level write lost");
  AST_LVL_LOCK: assert property (s_stat_wr ##0 NEST_DISABLE
    |=> $stable(CPU_LEVEL[2:0])) else $error("locked level changed");
  AST_TOP_SW: assert property ($rose(CPU_LEVEL[3]) |-> $past(CPU_LEVEL_LOAD))
    else $error("top level bit set without core load");
  AST_LOAD: assert property (CPU_LEVEL_LOAD && !AVS_WRITE
    |=> CPU_LEVEL == $past(CPU_LEVEL_IN)) else $error("core level load lost");
  // Level held three samples so the registered request has seen it
  AST_REQ_ABOVE: assert property (IRQ_REQ.valid && $stable(CPU_LEVEL)
    && $past(CPU_LEVEL, 2) == CPU_LEVEL |-> {1'b0, IRQ_REQ.prio} > CPU_LEVEL)
    else $error("request not above level");
  AST_VEC_ADDR: assert property (IRQ_REQ.valid && $stable(ALT_TABLE)
    && $past(ALT_TABLE, 2) == ALT_TABLE |-> IRQ_REQ.vec_addr == DEF_BASE
    + {16'h0000, IRQ_REQ.vec_num, 1'b0} + (ALT_TABLE ? ALT_OFS : 24'h000000))
    else $error("vector address wrong");
  AST_NEST_OUT: assert property (p_wr_bit(OFF_CTL_ONE, NEST_DISABLE))
    else $error("nest disable not updated");
  AST_ALT_OUT: assert property (p_wr_bit(OFF_CTL_TWO, ALT_TABLE))
    else $error("table select not updated");
endmodule // irq_ctrl_properties
bind irq_ctrl irq_ctrl_properties u_irq_ctrl_properties (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CPU_LEVEL_LOAD(CPU_LEVEL_LOAD),
  .CPU_LEVEL_IN(CPU_LEVEL_IN), .IRQ_REQ(IRQ_REQ), .CPU_LEVEL(CPU_LEVEL),
  .NEST_DISABLE(NEST_DISABLE), .ALT_TABLE(ALT_TABLE));
`default_nettype wire

// ==== dv/cpu_core_model.sv ====
// Purpose: CPU core stand-in that accepts requests and loads the level
// Assumes: Level load is a registered one-cycle pulse
// Notes:   Accepting raises the level to the winner's priority
`default_nettype none
module cpu_core_model (
  input  wire logic                    clk,
  input  wire logic                    take,
  input  wire logic                    set_lvl,
  input  wire logic [3:0]              set_val,
  input  wire irq_ctrl_pkg::irq_req_t  req,
  output logic                         load,
  output logic [3:0]                   lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  // Only a valid request is accepted; a forced load stands for trap entry
  always_ff @(posedge clk) begin
    load <= set_lvl || (take && req.valid);
    lvl  <= set_lvl ? set_val : {1'b0, req.prio};
  end
endmodule // cpu_core_model
`default_nettype wire

// ==== dv/irq_ctrl_test.sv ====
// Purpose: Self-checking bench for the interrupt controller
// Assumes: One wait state per bus access, idle cycle between accesses
// Notes:   Byte enables stay on the low half throughout
`default_nettype none
module irq_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_ctrl_pkg::*;
  logic        clk, rst, rd, wr, tdis, take, setl, wreq, ld, nest, alt;
  logic [5:0]  addr;
  logic [31:0] wdat, rdat;
  logic [3:0]  be, lvl, lvl_in, setv;
  logic [15:0] src, q, r, c2, en, fl;
  logic [2:0]  ext, lv;
  logic [47:0] pr;
  trap_ev_t    trap;
  irq_req_t    irq;
  int          miscompares, n_tests;
  irq_ctrl u_irq_ctrl (.SYS_CLK(clk), .SRST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .SRC_EVENT(src), .EXT_IRQ_PIN(ext), .TRAP_EVENT(trap),
    .TEMP_DISABLE(tdis), .CPU_LEVEL_LOAD(ld), .CPU_LEVEL_IN(lvl_in), .IRQ_REQ(irq),
    .CPU_LEVEL(lvl), .NEST_DISABLE(nest), .ALT_TABLE(alt));
  cpu_core_model u_cpu_core_model (.clk(clk), .take(take), .set_lvl(setl),
    .set_val(setv), .req(irq), .load(ld), .lvl(lvl_in));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    final_report();
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // Held until waitrequest is sampled low; read data taken at that edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdat <= {16'h0000, d};
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdat[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e, input string n);
    acc(1'b0, a, 16'h0000);
    chk(q, e, n);
  endtask
  task automatic pulse(input logic [15:0] m, input trap_ev_t t);
    @(posedge clk);
    src <= m;
    trap <= t;
    @(posedge clk);
    src <= 16'h0000;
    trap <= '0;
    repeat (3) @(posedge clk);
  endtask
  // Highest priority above the level wins, lower vector on a tie
  function automatic logic [31:0] expv(input logic [15:0] f, input logic [3:0] l,
                                       input logic a);
    logic [6:0] b;
    logic [2:0] bp;
    b = 7'h7F;
    bp = 3'h0;
    for (int i = 0; i < 16; i++) begin
      if (f[i] && pr[i*3+:3] > bp && {1'b0, pr[i*3+:3]} > l) begin
        b = 7'(i);
        bp = pr[i*3+:3];
      end
    end
    if (b == 7'h7F) return 32'h0;
    return {1'b1, b, DEF_BASE + {16'h0000, b, 1'b0} + (a ? ALT_OFS : 24'h000000)};
  endfunction
  initial begin
    {rst, rd, wr, tdis, take, setl} = 6'h20;
    {addr, wdat, src, ext, trap, setv} = '0;
    be = 4'h3;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'h85D5946C));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 12; a++) rdc(6'(a * 4), 16'h0000, "reset value");
    acc(1'b1, 6'h2C, 16'hFFFF);
    rdc(6'h2C, 16'h0000, "unmapped");
    $display("test reset done");
    // Core loads the top bit; software may only clear it
    setl <= 1'b1;
    setv <= 4'hA;
    @(posedge clk);
    setl <= 1'b0;
    repeat (3) @(posedge clk);
    chk(lvl, 4'hA, "level load");
    acc(1'b1, OFF_CORE, 16'hFFFF);
    rdc(OFF_CORE, 16'h0008, "core set");
    rdc(OFF_STATUS, 16'h0040, "status low");
    acc(1'b1, OFF_CORE, 16'h0000);
    rdc(OFF_CORE, 16'h0000, "core clear");
    acc(1'b1, OFF_CTL_ONE, 16'hFFE1);
    rdc(OFF_CTL_ONE, 16'h8000, "nest set");
    acc(1'b1, OFF_STATUS, 16'h00E0);
    rdc(OFF_STATUS, 16'h0040, "level locked");
    acc(1'b1, OFF_CTL_ONE, 16'h0000);
    pulse(16'h0000, 4'hF);
    rdc(OFF_CTL_ONE, 16'h001E, "trap flags");
    acc(1'b1, OFF_CTL_ONE, 16'h0000);
    rdc(OFF_CTL_ONE, 16'h0000, "trap clear");
    tdis <= 1'b1;
    rdc(OFF_CTL_TWO, 16'h4000, "temp disable");
    tdis <= 1'b0;
    $display("test control done");
    // External pin edge for each polarity
    for (int p = 0; p < 2; p++) begin
      acc(1'b1, OFF_CTL_TWO, 16'(p));
      ext <= p ? 3'h7 : 3'h0;
      repeat (4) @(posedge clk);
      acc(1'b1, OFF_FLAGS, 16'h0000);
      ext <= p ? 3'h0 : 3'h7;
      repeat (4) @(posedge clk);
      rdc(OFF_FLAGS, 16'h0001, "pin edge");
      acc(1'b1, OFF_FLAGS, 16'h0000);
      ext <= p ? 3'h7 : 3'h0;
      repeat (4) @(posedge clk);
      rdc(OFF_FLAGS, 16'h0000, "wrong edge");
    end
    $display("test pins done");
    // Random sources, priorities and levels; level 7 and a tie first
    for (int k = 0; k < 24; k++) begin
      c2 = 16'($urandom);
      acc(1'b1, OFF_CTL_TWO, c2);
      rdc(OFF_CTL_TWO, c2 & 16'h8007, "ctl two");
      en = k < 2 ? 16'hFFFF : 16'($urandom);
      acc(1'b1, OFF_ENABLE, en);
      rdc(OFF_ENABLE, en & FLAG_MASK, "enable");
      for (int i = 0; i < 4; i++) begin
        r = k < 2 ? 16'h7777 : 16'($urandom);
        acc(1'b1, 6'(OFF_PRIO0 + 4 * i), r);
        rdc(6'(OFF_PRIO0 + 4 * i), r & PRIO_MASK, "prio");
        for (int j = 0; j < 4; j++) pr[(4*i+j)*3+:3] = r[4*j+:3];
      end
      lv = k == 0 ? 3'h7 : (k == 1 ? 3'h0 : 3'($urandom));
      acc(1'b1, OFF_STATUS, {8'h00, lv, 5'h1F});
      rdc(OFF_STATUS, {8'h00, lv, 5'h00}, "status");
      chk(lvl, {1'b0, lv}, "level");
      acc(1'b1, OFF_FLAGS, 16'h0000);
      fl = k < 2 ? 16'h0088 : 16'($urandom);
      pulse(fl, '0);
      rdc(OFF_FLAGS, fl & FLAG_MASK, "flags");
      chk(irq.valid === 1'b1 ?
          {irq.valid, irq.vec_num, irq.vec_addr} : 32'h0,
          expv(fl & en & FLAG_MASK, {1'b0, lv}, c2[15]), "winner");
      if (irq.valid === 1'b1) begin
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        repeat (4) @(posedge clk);
        chk(irq.valid, 1'b0, "after take");
      end
    end
    $display("test random done");
    final_report();
  end
endmodule // irq_ctrl_test
`default_nettype wire
